// File: sram_timing_pkg.sv
package sram_timing_pkg;

    // ****************************************
    // Bus widths
    // ****************************************
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // ****************************************
    // Timing, ns as printed (slower grade)
    // ****************************************
    localparam int CLK_PERIOD_NS    = 10;
    localparam int WRITE_PULSE_NS   = 40;  // Write window width
    localparam int ADDR_TO_END_NS   = 50;  // Address / select / lane valid to write end
    localparam int DATA_SETUP_NS    = 25;  // data_setup_to_write_end
    localparam int DATA_HOLD_NS     = 0;   // data_hold_after_write
    localparam int RECOVERY_NS      = 0;   // write_recovery_interval
    localparam int BUS_RELEASE_NS   = 5;   // Device re-drives no sooner than this
    localparam int READ_ACCESS_NS   = 55;  // Select / lane access
    localparam int OE_ACCESS_NS     = 35;
    localparam int READ_FLOAT_NS    = 20;  // Device floats after deselect
    localparam int RETAIN_SETUP_NS  = 0;   // Deselect to retention

    // ****************************************
    // Cycle counts, least times rounded up, none below one
    // ****************************************
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WR_PULSE_CYC = cyc_up(ADDR_TO_END_NS) > cyc_up(WRITE_PULSE_NS) ?
                                  cyc_up(ADDR_TO_END_NS) : cyc_up(WRITE_PULSE_NS);
    localparam int WR_HOLD_CYC  = cyc_up(DATA_HOLD_NS + BUS_RELEASE_NS);
    localparam int RD_WAIT_CYC  = cyc_up(READ_ACCESS_NS) + 2;  // Plus input synchroniser
    localparam int RD_FLOAT_CYC = cyc_up(READ_FLOAT_NS);
    localparam int CNT_W        = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_WPULSE = 6'b000010,
        ST_WHOLD  = 6'b000100,
        ST_RWAIT  = 6'b001000,
        ST_RFLOAT = 6'b010000,
        ST_RETAIN = 6'b100000
    } ctl_state_t;

endpackage

// File: sram_host_ctrl.sv
`timescale 1ns/1ps

// Operation
// - Write only while primary low, secondary high, strobe low, a lane low.
// - Host holds the write window at least 35/40 ns.
// - Address stable 45/50 ns before write window ends.
// - Both selects active 45/50 ns before write ends.
// - Byte lane selects valid 45/50 ns before write ends.
// - Address valid no later than write start, setup 0 ns.
// - Address held at least 0 ns after write end before new cycle.
// - Write data valid 25 ns before write end, held 0 ns after.
// - Retention by secondary select lets other inputs float.
// - Retention by primary select needs secondary select held firm.
// - Deselect before supply drops to retention level, 0 ns minimum.
module sram_host_ctrl (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    // User request side
    input  wire logic                          req_valid,
    input  wire logic                          req_write,
    input  wire logic [sram_timing_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [sram_timing_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [1:0]                    req_lanes,
    input  wire logic                          retain_req,
    output logic                               req_ready,
    output logic                               rd_valid,
    output logic [sram_timing_pkg::DATA_W-1:0] rd_data,
    output logic                               retain_active,
    // Memory pins
    output logic [sram_timing_pkg::ADDR_W-1:0] mem_addr,
    output logic                               primary_select_n,
    output logic                               secondary_select,
    output logic                               write_strobe_n,
    output logic                               output_enable_n,
    output logic                               low_lane_select_n,
    output logic                               high_lane_select_n,
    input  wire logic [sram_timing_pkg::DATA_W-1:0] mem_dq_in,
    output logic [sram_timing_pkg::DATA_W-1:0] mem_dq_out,
    output logic                               mem_dq_oe
);
    import sram_timing_pkg::*;

    // ****************************************
    // Data pin synchroniser
    // ****************************************
    logic [DATA_W-1:0] dq_s1_ff;
    logic [DATA_W-1:0] dq_s2_ff;

    // Two stages before anything reads the pad
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
        end else begin
            dq_s1_ff <= mem_dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    ctl_state_t        state_ff,  nxt_state;
    logic [CNT_W-1:0]  cnt_ff,    nxt_cnt;
    logic [ADDR_W-1:0] addr_ff,   nxt_addr;
    logic [DATA_W-1:0] wdat_ff,   nxt_wdat;
    logic              psel_ff,   nxt_psel;
    logic              ssel_ff,   nxt_ssel;
    logic              we_ff,     nxt_we;
    logic              oe_ff,     nxt_oe;
    logic [1:0]        lane_ff,   nxt_lane;
    logic              drv_ff,    nxt_drv;
    logic              rdy_ff,    nxt_rdy;
    logic              rv_ff,     nxt_rv;
    logic [DATA_W-1:0] rdat_ff,   nxt_rdat;
    logic              ret_ff,    nxt_ret;

    // Next-state logic; all pins change together only at cycle starts,
    // so every setup is a whole number of cycles, zero for address to write start
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_addr  = addr_ff;
        nxt_wdat  = wdat_ff;
        nxt_psel  = psel_ff;
        nxt_ssel  = ssel_ff;
        nxt_we    = we_ff;
        nxt_oe    = oe_ff;
        nxt_lane  = lane_ff;
        nxt_drv   = drv_ff;
        nxt_rdy   = 1'b0;
        nxt_rv    = 1'b0;
        nxt_rdat  = rdat_ff;
        nxt_ret   = ret_ff;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_rdy = !retain_req && !req_valid;
                if (retain_req) begin
                    nxt_ssel  = 1'b0;
                    nxt_psel  = 1'b1;
                    nxt_lane  = 2'b11;
                    nxt_ret   = 1'b1;
                    nxt_state = ST_RETAIN;
                end else if (req_valid && rdy_ff) begin
                    // address, selects and lanes open together
                    nxt_addr = req_addr;
                    nxt_psel = 1'b0;
                    nxt_ssel = 1'b1;
                    nxt_lane = ~req_lanes;
                    if (req_write) begin
                        nxt_wdat  = req_wdata;
                        nxt_we    = 1'b0;
                        nxt_drv   = 1'b1;
                        nxt_cnt   = CNT_W'(WR_PULSE_CYC - 1);
                        nxt_state = ST_WPULSE;
                    end else begin
                        nxt_oe    = 1'b0;
                        nxt_cnt   = CNT_W'(RD_WAIT_CYC - 1);
                        nxt_state = ST_RWAIT;
                    end
                end
            end
            ST_WPULSE: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_we    = 1'b1;
                    nxt_psel  = 1'b1;
                    nxt_lane  = 2'b11;
                    nxt_cnt   = CNT_W'(WR_HOLD_CYC - 1);
                    nxt_state = ST_WHOLD;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_WHOLD: begin
                // address and data held, bus released later
                if (cnt_ff == CNT_ZERO) begin
                    nxt_drv   = 1'b0;
                    nxt_rdy   = 1'b1;
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_RWAIT: begin
                // sample after worst access plus sync
                if (cnt_ff == CNT_ZERO) begin
                    nxt_rdat[7:0]  = lane_ff[0] ? 8'h00 : dq_s2_ff[7:0];
                    nxt_rdat[15:8] = lane_ff[1] ? 8'h00 : dq_s2_ff[15:8];
                    nxt_rv    = 1'b1;
                    nxt_oe    = 1'b1;
                    nxt_psel  = 1'b1;
                    nxt_lane  = 2'b11;
                    nxt_cnt   = CNT_W'(RD_FLOAT_CYC - 1);
                    nxt_state = ST_RFLOAT;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_RFLOAT: begin
                // wait for the device to float before a write drives
                if (cnt_ff == CNT_ZERO) begin
                    nxt_rdy   = 1'b1;
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            ST_RETAIN: begin
                // secondary held firm low, others parked
                if (!retain_req) begin
                    nxt_ret   = 1'b0;
                    nxt_ssel  = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    // Registers only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= CNT_ZERO;
            addr_ff  <= '0;
            wdat_ff  <= '0;
            psel_ff  <= 1'b1;
            ssel_ff  <= 1'b0;
            we_ff    <= 1'b1;
            oe_ff    <= 1'b1;
            lane_ff  <= 2'b11;
            drv_ff   <= 1'b0;
            rdy_ff   <= 1'b0;
            rv_ff    <= 1'b0;
            rdat_ff  <= '0;
            ret_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            addr_ff  <= nxt_addr;
            wdat_ff  <= nxt_wdat;
            psel_ff  <= nxt_psel;
            ssel_ff  <= nxt_ssel;
            we_ff    <= nxt_we;
            oe_ff    <= nxt_oe;
            lane_ff  <= nxt_lane;
            drv_ff   <= nxt_drv;
            rdy_ff   <= nxt_rdy;
            rv_ff    <= nxt_rv;
            rdat_ff  <= nxt_rdat;
            ret_ff   <= nxt_ret;
        end
    end

    // ****************************************
    // Outputs straight from flops
    // ****************************************
    assign req_ready          = rdy_ff;
    assign rd_valid           = rv_ff;
    assign rd_data            = rdat_ff;
    assign retain_active      = ret_ff;
    assign mem_addr           = addr_ff;
    assign primary_select_n   = psel_ff;
    assign secondary_select   = ssel_ff;
    assign write_strobe_n     = we_ff;
    assign output_enable_n    = oe_ff;
    assign low_lane_select_n  = lane_ff[0];
    assign high_lane_select_n = lane_ff[1];
    assign mem_dq_out         = wdat_ff;
    assign mem_dq_oe          = drv_ff;

endmodule

// File: sram_host_ctrl_properties.sv
`timescale 1ns/1ps
// ****
// Controller pin checks
// ****
module sram_host_ctrl_properties import sram_timing_pkg::*; (
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              rd_valid,
    input wire logic              retain_active,
    input wire logic              primary_select_n,
    input wire logic              secondary_select,
    input wire logic              write_strobe_n,
    input wire logic              output_enable_n,
    input wire logic              low_lane_select_n,
    input wire logic              high_lane_select_n,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] mem_dq_out,
    input wire logic              mem_dq_oe
);
    // One domain, so clock and reset are stated once
    default clocking dck @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_select_span: assert property (
        $fell(write_strobe_n) |-> (!primary_select_n && secondary_select) [*5])
        else $error("selects dropped inside write window");
    // Zero-lane cycles keep both selects high, so the lanes are checked for hold only
    chk_lane_span: assert property (
        $fell(write_strobe_n) |=> $stable({low_lane_select_n, high_lane_select_n}) [*4])
        else $error("lane selects moved inside write window");
    chk_pulse_width: assert property (
        $fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
        else $error("write strobe width wrong");
    chk_addr_hold: assert property (
        $fell(write_strobe_n) |=> $stable(mem_addr) [*5])
        else $error("address moved during write");
    chk_data_hold: assert property (
        $fell(write_strobe_n) |=> (mem_dq_oe && $stable(mem_dq_out)) [*5])
        else $error("write data not held to write end");
    chk_bus_turn: assert property (
        !output_enable_n |-> !mem_dq_oe && write_strobe_n)
        else $error("host drives bus while output enabled");
    chk_retain_pins: assert property (
        retain_active |-> !secondary_select && primary_select_n)
        else $error("retention without deselect");
    chk_read_wait: assert property (
        $fell(output_enable_n) |-> !rd_valid [*8] ##1 rd_valid)
        else $error("read sampled at wrong time");
endmodule

bind sram_host_ctrl sram_host_ctrl_properties u_props (
    .mclk(mclk), .rst_n(rst_n), .rd_valid(rd_valid), .retain_active(retain_active),
    .primary_select_n(primary_select_n), .secondary_select(secondary_select),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .low_lane_select_n(low_lane_select_n), .high_lane_select_n(high_lane_select_n),
    .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe)
);

// File: sram_dev_model.sv
`timescale 1ns/1ps
// ****
// Behavioural memory device
// ****
module sram_dev_model import sram_timing_pkg::*; #(
    parameter int ACC_NS = 55
) (
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              primary_select_n,
    input  wire logic              secondary_select,
    input  wire logic              write_strobe_n,
    input  wire logic              output_enable_n,
    input  wire logic              low_lane_select_n,
    input  wire logic              high_lane_select_n,
    input  wire logic [DATA_W-1:0] mem_dq_out,
    input  wire logic              mem_dq_oe,
    output logic      [DATA_W-1:0] mem_dq_in
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] flt = 16'hA5C3;
    logic [1:0]        wr_lanes;
    logic              wr_on, rd_on, rd_ok;
    logic [ADDR_W-1:0] rd_addr;
    assign wr_on = !primary_select_n && secondary_select && !write_strobe_n
                   && !(low_lane_select_n && high_lane_select_n);
    // read path, data only after the access time
    assign rd_on = !primary_select_n && secondary_select && write_strobe_n && !output_enable_n;
    // A deselect leaves an earlier pending rise in place, so after a short gap between reads data can come early
    always @(rd_on) begin
        if (rd_on)
            rd_ok <= #(ACC_NS) 1'b1;
        else
            rd_ok = 1'b0;
    end
    // old address keeps steering the outputs for 10 ns
    always @(mem_addr) rd_addr <= #10 mem_addr;
    // Lanes taken just after window start, once both lane pins have settled
    always @(posedge wr_on) #1 wr_lanes = {!high_lane_select_n, !low_lane_select_n};
    always @(negedge wr_on) begin : commit
        logic [DATA_W-1:0] w;
        w = mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 16'h0000;
        if (wr_lanes[0]) w[7:0] = mem_dq_out[7:0];
        if (wr_lanes[1]) w[15:8] = mem_dq_out[15:8];
        mem[int'(mem_addr)] = w;
    end
    // Released bus wanders, so a stale value never reads as good
    always #7 flt = {flt[14:0], ~flt[15]};
    always @* begin
        mem_dq_in = mem_dq_oe ? mem_dq_out : flt;
        if (!mem_dq_oe && rd_on && rd_ok) begin
            if (!low_lane_select_n) mem_dq_in[7:0] = mem[int'(rd_addr)][7:0];
            if (!high_lane_select_n) mem_dq_in[15:8] = mem[int'(rd_addr)][15:8];
        end
    end
endmodule

// File: async_sram_access_timing_tb_top.sv
`timescale 1ns/1ps
// ****
// Controller bench with behavioural memory
// ****
module async_sram_access_timing_tb_top;
    import sram_timing_pkg::*;
    logic              mclk, rst_n, req_valid, req_write, retain_req, req_ready, rd_valid;
    logic              retain_active, primary_select_n, secondary_select, write_strobe_n;
    logic              output_enable_n, low_lane_select_n, high_lane_select_n, mem_dq_oe;
    logic [1:0]        req_lanes;
    logic [ADDR_W-1:0] req_addr, mem_addr;
    logic [DATA_W-1:0] req_wdata, rd_data, mem_dq_in, mem_dq_out;
    int                fails, num_checks;

    sram_host_ctrl u_dut (.*);
    // Slowest legal access, so the read wait is tried at its margin
    sram_dev_model #(.ACC_NS(55)) u_mem (.*);

    // Free-running clock
    always #5 mclk = ~mclk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk16(input string what, input logic [DATA_W-1:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Bounded wait on ready (0), read valid (1) or retention (2)
    task automatic wait_sig(input int which);
        int   n;
        logic s;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            s = (which == 0) ? req_ready : (which == 1) ? rd_valid : retain_active;
        end while (s !== 1'h1 && n < 40);
        if (s !== 1'h1) begin
            fails++;
            $display("ERROR wait %0d expected 1 seen %b", which, s);
            end_of_test();
        end
    endtask

    // Request held until taken, then run to completion
    task automatic op(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [1:0] l);
        req_valid <= 1'h1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        req_lanes <= l;
        wait_sig(0);
        req_valid <= 1'h0;
        if (!w)
            wait_sig(1);
        wait_sig(0);
    endtask

    task automatic t_word_lanes();
        op(1'h1, 20'h00000, 16'h1234, 2'h3);
        op(1'h0, 20'h00000, 16'h0000, 2'h3);
        chk16("full read", 16'h1234, rd_data);
        op(1'h0, 20'h00000, 16'h0000, 2'h1);
        chk16("low lane read", 16'h0034, rd_data);
        op(1'h0, 20'h00000, 16'h0000, 2'h2);
        chk16("high lane read", 16'h1200, rd_data);
    endtask

    // Partial and empty lane writes at the top address
    task automatic t_lane_write();
        op(1'h1, 20'hFFFFF, 16'hABCD, 2'h3);
        op(1'h1, 20'hFFFFF, 16'h5566, 2'h1);
        op(1'h1, 20'hFFFFF, 16'h7788, 2'h2);
        op(1'h1, 20'hFFFFF, 16'hFFFF, 2'h0);
        op(1'h0, 20'hFFFFF, 16'h0000, 2'h3);
        chk16("lane merge", 16'h7766, rd_data);
    endtask

    task automatic t_retain();
        retain_req <= 1'h1;
        wait_sig(2);
        chk1("secondary select", 1'h0, secondary_select);
        chk1("primary select", 1'h1, primary_select_n);
        retain_req <= 1'h0;
        wait_sig(0);
        op(1'h0, 20'h00000, 16'h0000, 2'h3);
        chk16("kept data", 16'h1234, rd_data);
    endtask

    // Reset for two cycles, then the scenarios
    initial begin
        mclk = 1'h0;
        rst_n = 1'h0;
        req_valid = 1'h0;
        req_write = 1'h0;
        retain_req = 1'h0;
        req_lanes = 2'h0;
        req_addr = 20'h00000;
        req_wdata = 16'h0000;
        fails = 0;
        num_checks = 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        // In idle, ready only rises while no request is pending, so idle first
        wait_sig(0);
        t_word_lanes();
        t_lane_write();
        t_retain();
        end_of_test();
    end
endmodule
